// [lss_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
// Fault control and serial status for the eight-output low-side switch.
module lss_ctrl (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire lss_pkg::lss_ser_t SER_IN,
    input wire logic SHORT_FAULT_PROTECT_SELECT,
    input wire logic LOGIC_SUPPLY_UV,
    input wire logic LOAD_SUPPLY_UV,
    input wire logic LOAD_SUPPLY_OV,
    input wire lss_pkg::lss_sense_t SENSE,
    output logic SDO,
    output logic [7:0] OUT_ON
);
    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [7:0] shift;
        logic [7:0] cmd;
        logic [7:0] status;
        logic [2:0] bits;
        logic sclk_d;
        logic cs_d;
        logic ov_latched;
        logic sdo;
        logic [7:0] drive;
    } lss_st_t;
    lss_st_t st_ff;
    lss_st_t nxt_st;
    logic cs_rise;
    logic cs_fall;
    logic sclk_rise;
    logic sclk_fall;
    logic delay_done;
    logic filter_done;
    logic [7:0] drive_on;
    logic [7:0] out_on;
    logic [7:0] cmd_on;
    logic [7:0] stat_now;

    ////////////////////////////////////////////////////////////////////////////
    // Pin edges; pins are already synchronous
    assign cs_rise = SER_IN.cs_n && !st_ff.cs_d;
    assign cs_fall = !SER_IN.cs_n && st_ff.cs_d;
    assign sclk_rise = SER_IN.sclk && !st_ff.sclk_d;
    assign sclk_fall = !SER_IN.sclk && st_ff.sclk_d;
    // Low commands on, high commands off
    assign cmd_on = ~st_ff.cmd; // RULE_08

    ////////////////////////////////////////////////////////////////////////////
    // Timers: shared by all outputs, started at the latch edge
    lss_timer #(.CYCLES(lss_pkg::SHORT_DELAY_CYC)) u_short_tmr (
        .SYS_CLK(SYS_CLK),
        .NRST(NRST),
        .start(cs_rise), // RULE_16
        .done(delay_done)
    );
    lss_timer #(.CYCLES(lss_pkg::FILTER_DELAY_CYC)) u_filter_tmr (
        .SYS_CLK(SYS_CLK),
        .NRST(NRST),
        .start(cs_rise), // RULE_17
        .done(filter_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Per-output latch, one select for every output
    for (genvar i = 0; i < lss_pkg::NUM_OUT; i++) begin : g_chan
        lss_chan u_chan (
            .SYS_CLK(SYS_CLK),
            .NRST(NRST),
            .new_word(cs_rise),
            .cmd_on(cmd_on[i]),
            .protect_sel(SHORT_FAULT_PROTECT_SELECT), // RULE_04
            .delay_done(delay_done),
            .short_det(SENSE.short_det[i]),
            .over_temp(SENSE.over_temp[i]),
            .drive_on(drive_on[i])
        );
    end

    // Over-voltage and logic under-voltage override every output
    assign out_on = (LOGIC_SUPPLY_UV || LOAD_SUPPLY_OV || st_ff.ov_latched) ? 8'h00 : drive_on; // RULE_05 RULE_14

    ////////////////////////////////////////////////////////////////////////////
    // Status word: equals command unless a fault is seen
    always_comb begin
        stat_now = st_ff.cmd;
        for (int i = 0; i < lss_pkg::NUM_OUT; i++) begin
            if (!cmd_on[i] && filter_done && SENSE.open_det[i]) begin
                stat_now[i] = 1'b0; // RULE_09 RULE_17
            end else if (cmd_on[i] && (SENSE.short_det[i] || SENSE.over_temp[i])) begin
                stat_now[i] = 1'b1; // RULE_10 RULE_11 RULE_07
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial shift, latch and supply handling
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sclk_d = SER_IN.sclk;
        nxt_st.cs_d = SER_IN.cs_n;
        // Output pins come from flip-flops, one cycle after the cause
        nxt_st.drive = out_on;
        // Track the live status so the capture sees the latest faults
        nxt_st.status = stat_now;
        if (cs_fall) begin
            // Capture at frame start, first bit out at once
            nxt_st.shift = st_ff.status; // RULE_18
            nxt_st.sdo = st_ff.status[7]; // RULE_15
            nxt_st.bits = lss_pkg::CNT_RST;
        end else if (!SER_IN.cs_n && sclk_rise) begin
            nxt_st.shift = {st_ff.shift[6:0], SER_IN.sdi}; // RULE_15
            nxt_st.bits = st_ff.bits + 3'h1;
        end else if (!SER_IN.cs_n && sclk_fall) begin
            nxt_st.sdo = st_ff.shift[7]; // RULE_15
        end
        if (cs_rise) begin
            // Load-supply under-voltage deliberately does not block the load
            nxt_st.cmd = st_ff.shift; // RULE_06
            nxt_st.ov_latched = 1'b0; // RULE_14
        end
        if (LOAD_SUPPLY_OV) begin
            nxt_st.ov_latched = 1'b1; // RULE_14
        end
        if (LOGIC_SUPPLY_UV) begin
            // Outputs and reported status both show off
            nxt_st.cmd = lss_pkg::CMD_RST; // RULE_05
            nxt_st.status = lss_pkg::STAT_RST; // RULE_05
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            st_ff <= '{shift: lss_pkg::SHIFT_RST, cmd: lss_pkg::CMD_RST,
                status: lss_pkg::STAT_RST, bits: lss_pkg::CNT_RST, sclk_d: 1'b0,
                cs_d: 1'b1, ov_latched: 1'b0, sdo: 1'b0, drive: lss_pkg::OUT_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Pins straight from the state flip-flops, no logic after them
    assign OUT_ON = st_ff.drive;
    assign SDO = st_ff.sdo;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    uv_all_off_a: assert property (@(posedge SYS_CLK) disable iff (!NRST) // RULE_05
        LOGIC_SUPPLY_UV |=> (OUT_ON == 8'h00) && (st_ff.status == 8'hff))
        else $error("under-voltage left an output on");
    ov_latch_a: assert property (@(posedge SYS_CLK) disable iff (!NRST) // RULE_14
        (LOAD_SUPPLY_OV ##1 (!cs_rise && !LOAD_SUPPLY_OV)) |=> (OUT_ON == 8'h00))
        else $error("over-voltage latch released without new word");
    temp_off_a: assert property (@(posedge SYS_CLK) disable iff (!NRST) // RULE_13
        SENSE.over_temp[0] |=> !OUT_ON[0])
        else $error("hot output stayed on");
    limit_on_a: assert property (@(posedge SYS_CLK) disable iff (!NRST) // RULE_12
        (SHORT_FAULT_PROTECT_SELECT && cmd_on[0] && !SENSE.over_temp[0] && !LOGIC_SUPPLY_UV
         && !LOAD_SUPPLY_OV && !st_ff.ov_latched) |=> OUT_ON[0])
        else $error("current-limited output switched off");
    oc_report_a: assert property (@(posedge SYS_CLK) disable iff (!NRST) // RULE_10
        (cmd_on[1] && SENSE.short_det[1] && !LOGIC_SUPPLY_UV) |=> st_ff.status[1])
        else $error("over-current not reported");
    open_report_a: assert property (@(posedge SYS_CLK) disable iff (!NRST) // RULE_09
        (!cmd_on[2] && filter_done && SENSE.open_det[2] && !LOGIC_SUPPLY_UV) |=> !st_ff.status[2])
        else $error("open load not reported");
    filter_hold_a: assert property (@(posedge SYS_CLK) disable iff (!NRST) // RULE_17
        (cs_rise && !LOGIC_SUPPLY_UV) ##1 (!cs_rise && !LOGIC_SUPPLY_UV)
        |=> (st_ff.status[3] == st_ff.cmd[3] || cmd_on[3]))
        else $error("open load seen inside filter");
    status_capture_a: assert property (@(posedge SYS_CLK) disable iff (!NRST) // RULE_18
        cs_fall |=> (st_ff.shift == $past(st_ff.status)) && (SDO == $past(st_ff.status[7])))
        else $error("status not captured at frame start");
    cmd_load_a: assert property (@(posedge SYS_CLK) disable iff (!NRST) // RULE_07
        (cs_rise && !LOGIC_SUPPLY_UV) |=> st_ff.cmd == $past(st_ff.shift))
        else $error("command word not latched");
    load_uv_cmd_a: assert property (@(posedge SYS_CLK) disable iff (!NRST) // RULE_06
        (cs_rise && LOAD_SUPPLY_UV && !LOGIC_SUPPLY_UV) |=> st_ff.cmd == $past(st_ff.shift))
        else $error("command word refused under load-supply low voltage");
endmodule // lss_ctrl
`default_nettype wire

// [lss_pkg.sv]
// Function
// RULE_01: Select high: current-limited output resumes by itself once short is gone, unless overheated.
// RULE_02: Select low: output shut for over-current stays off until next write cycle.
// RULE_03: Select low, short present: each on-command runs output for fault delay, then off.
// RULE_04: One select input governs shutdown versus current limit for all eight outputs.
// RULE_05: Logic-supply under-voltage turns all outputs off and resets status to all off.
// RULE_06: Load-supply under-voltage causes no shutdown; outputs follow command, status unreliable.
// RULE_07: Status bit equal to previous command bit means no fault; differing means fault.
// RULE_08: Host commands an output off with high and on with low.
// RULE_09: Output commanded off with open load returns low in its status bit.
// RULE_10: Output commanded on with over-current returns high in its status bit.
// RULE_11: Over-current is always reported whatever the select input says.
// RULE_12: Select high: over-current output stays on current-limited unless over-temperature occurs.
// RULE_13: Over-temperature shuts only the affected output, only while the condition lasts.
// RULE_14: Load-supply over-voltage switches off and latches all outputs until a new command word.
// RULE_15: All eight status bits shift out on the one serial output per transfer.
// RULE_16: Short before or during turn-on delay shuts at delay end; later short immediately.
// RULE_17: Open-load result is ignored until the fault filter timer after strobe rise expires.
// RULE_18: Status captured at strobe fall shifts out during the following write cycle.
`default_nettype none
package lss_pkg;
    localparam int unsigned NUM_OUT = 8;
    localparam int unsigned CLK_MHZ = 200;
    // Least times, rounded up to whole cycles
    localparam int unsigned SHORT_DELAY_US = 70;
    localparam int unsigned FILTER_DELAY_US = 25;
    localparam int unsigned SHORT_DELAY_CYC = SHORT_DELAY_US * CLK_MHZ;
    localparam int unsigned FILTER_DELAY_CYC = FILTER_DELAY_US * CLK_MHZ;
    localparam int unsigned TMR_W = 16;
    localparam logic [7:0] CMD_RST = 8'hff;
    localparam logic [7:0] STAT_RST = 8'hff;
    localparam logic [2:0] CNT_RST = 3'h0;
    localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;
    localparam logic [7:0] SHIFT_RST = 8'h00;
    localparam logic [7:0] OUT_RST = 8'h00;

    // Fault conditions sensed per output
    typedef struct packed {
        logic [7:0] short_det;
        logic [7:0] open_det;
        logic [7:0] over_temp;
    } lss_sense_t;

    // Serial pins of the command port
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic sdi;
    } lss_ser_t;
endpackage
`default_nettype wire

// [lss_timer.sv]
`timescale 1ns/100ps
`default_nettype none
// One-shot delay timer, restarted by start, done once count expires
module lss_timer #(
    parameter int unsigned CYCLES = 16
) (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic start,
    output logic done
);
    typedef struct packed {
        logic [lss_pkg::TMR_W-1:0] cnt;
        logic done;
    } lss_tmr_st_t;
    localparam logic [lss_pkg::TMR_W-1:0] LAST = lss_pkg::TMR_W'(CYCLES - 1);
    lss_tmr_st_t st_ff;
    lss_tmr_st_t nxt_st;

    // Count from start up to the last cycle, then hold done
    always_comb begin
        nxt_st = st_ff;
        if (start) begin
            nxt_st.cnt = lss_pkg::TMR_RST;
            nxt_st.done = 1'b0;
        end else if (!st_ff.done) begin
            if (st_ff.cnt == LAST) begin
                nxt_st.done = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt + 1'b1;
            end
        end
    end

    // Done after reset so no false delay before the first frame
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            st_ff <= '{cnt: lss_pkg::TMR_RST, done: 1'b1};
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign done = st_ff.done;
endmodule // lss_timer
`default_nettype wire

// [lss_chan.sv]
`timescale 1ns/100ps
`default_nettype none
// Over-current latch of one output
module lss_chan (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic new_word,
    input wire logic cmd_on,
    input wire logic protect_sel,
    input wire logic delay_done,
    input wire logic short_det,
    input wire logic over_temp,
    output logic drive_on
);
    typedef struct packed {
        logic oc_latched;
    } lss_chan_st_t;
    lss_chan_st_t st_ff;
    lss_chan_st_t nxt_st;

    // Latch trips only in shutdown mode, and only once the delay is over
    always_comb begin
        nxt_st = st_ff;
        if (new_word) begin
            nxt_st.oc_latched = 1'b0; // RULE_02
        end else if (!protect_sel && cmd_on && short_det && delay_done) begin
            nxt_st.oc_latched = 1'b1; // RULE_03 RULE_16
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            st_ff <= '{oc_latched: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Current limit keeps output on when select high; heat shuts it meanwhile
    assign drive_on = cmd_on && !over_temp && !(st_ff.oc_latched && !protect_sel); // RULE_01 RULE_12 RULE_13

    latch_trip_a: assert property (@(posedge SYS_CLK) disable iff (!NRST) // RULE_16
        (!protect_sel && cmd_on && short_det && delay_done && !new_word)
        |=> (st_ff.oc_latched))
        else $error("over-current latch did not trip");
endmodule // lss_chan
`default_nettype wire

// [lss_host.sv]
`timescale 1ns/100ps
`default_nettype none
// Host end of the command port: clocks one word in, collects the status word
module lss_host (
    input wire logic SYS_CLK,
    input wire logic SDO,
    output var lss_pkg::lss_ser_t SER_IN
);
    // Idle: deselected, serial clock parked low
    initial begin
        SER_IN = '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
    end
    ////////////////////////////////
    // Changes land just after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask
    // Three cycles per phase, so every sclk level is seen at least twice
    task automatic xfer(input logic [7:0] cmd, output logic [7:0] stat);
        SER_IN.cs_n = 1'b0;
        cyc(3);
        for (int i = 7; i >= 0; i--) begin
            stat[i] = SDO;
            SER_IN.sdi = cmd[i];
            cyc(3);
            SER_IN.sclk = 1'b1;
            cyc(3);
            SER_IN.sclk = 1'b0;
            cyc(3);
        end
        SER_IN.cs_n = 1'b1;
        // Released data line no longer shows the last bit
        SER_IN.sdi = ~SER_IN.sdi;
        cyc(3);
    endtask
endmodule // lss_host
`default_nettype wire

// [low_side_switch_fault_control_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module low_side_switch_fault_control_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sel = 1'b1;
    logic lsuv = 1'b0;
    logic luv = 1'b0;
    logic ov = 1'b0;
    lss_pkg::lss_sense_t sense = '0;
    lss_pkg::lss_ser_t ser;
    logic sdo;
    logic [7:0] out_on;
    logic [7:0] m_cmd = 8'hff;
    logic [7:0] m_lat = 8'h00;
    logic m_ov = 1'b0;
    int fails = 0;
    int n_tests = 0;
    ////////////////////////////////
    lss_ctrl lss_ctrl_inst (.SYS_CLK(clk), .NRST(nrst), .SER_IN(ser),
        .SHORT_FAULT_PROTECT_SELECT(sel), .LOGIC_SUPPLY_UV(lsuv),
        .LOAD_SUPPLY_UV(luv), .LOAD_SUPPLY_OV(ov), .SENSE(sense),
        .SDO(sdo), .OUT_ON(out_on));
    lss_host lss_host_inst (.SYS_CLK(clk), .SDO(sdo), .SER_IN(ser));
    // 200 MHz clock
    always #2.5 clk = ~clk;
    ////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Model outputs: word in force, minus latched, hot or over-voltage outputs
    function automatic logic [7:0] exp_on();
        return ~m_cmd & ~m_lat & ~sense.over_temp & {8{~m_ov}};
    endfunction
    // Status reports on the word in force, then the new word takes over
    task automatic frame(input logic [7:0] cmd, input logic filt);
        logic [7:0] st;
        logic [7:0] exp;
        // Let a fresh fault level reach the live status before the capture edge
        cyc(1);
        exp = m_cmd & ~(sense.open_det & {8{filt}});
        exp = exp | (~m_cmd & (sense.short_det | sense.over_temp));
        lss_host_inst.xfer(cmd, st);
        chk(st, exp);
        m_cmd = cmd;
        m_lat = 8'h00;
        m_ov = 1'b0;
        chk(out_on, exp_on());
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////
    // Watchdog: the sequence needs about 50k cycles, allow 80k
    initial begin
        #400000;
        fails++;
        results();
    end
    // Main sequence
    initial begin
        logic [7:0] r;
        void'($urandom(32'he921));
        cyc(2);
        nrst = 1'b1;
        chk(out_on, 8'h00);
        for (int i = 0; i < 4; i++) frame(8'($urandom), 1'b1);
        // Open loads hidden until the filter after the strobe runs out
        frame(8'h0f, 1'b1);
        sense.open_det = 8'($urandom);
        frame(8'h0f, 1'b0);
        cyc(5100);
        frame(8'h0f, 1'b1);
        sense.open_det = 8'h00;
        // Limit mode: shorted outputs keep running and are reported
        r = 8'($urandom);
        sense.short_det = r;
        cyc(14200);
        chk(out_on, exp_on());
        frame(8'h00, 1'b1);
        sense.short_det = 8'h00;
        cyc(3);
        chk(out_on, 8'hff);
        sense.over_temp = 8'h10;
        cyc(3);
        chk(out_on, exp_on());
        sense.over_temp = 8'h00;
        cyc(3);
        chk(out_on, 8'hff);
        // Shutdown mode: standing short trips every output at delay end
        sel = 1'b0;
        sense.short_det = 8'hff;
        frame(8'h00, 1'b1);
        cyc(13800);
        chk(out_on, 8'hff);
        cyc(400);
        m_lat = 8'hff;
        chk(out_on, exp_on());
        sense.short_det = 8'h00;
        cyc(20);
        chk(out_on, exp_on());
        frame(8'h00, 1'b1);
        cyc(14100);
        sense.short_det = 8'h04;
        cyc(4);
        m_lat = 8'h04;
        chk(out_on, exp_on());
        sense.short_det = 8'h00;
        // Over-voltage latches all off until a fresh word
        frame(8'h00, 1'b1);
        ov = 1'b1;
        cyc(3);
        ov = 1'b0;
        m_ov = 1'b1;
        cyc(3);
        chk(out_on, exp_on());
        frame(8'h00, 1'b1);
        luv = 1'b1;
        frame(8'h5a, 1'b1);
        luv = 1'b0;
        lsuv = 1'b1;
        cyc(3);
        m_cmd = 8'hff;
        chk(out_on, exp_on());
        lsuv = 1'b0;
        cyc(2);
        frame(8'h00, 1'b1);
        results();
    end
endmodule // low_side_switch_fault_control_tb
`default_nettype wire
